// ==== hdl/ach_axis.sv ====
module ach_axis import ach_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Scan and commands
   input wire logic scan_tick,
   input wire ach_cmd_type cmd,
   // Positioning requests from the program engine
   input wire logic start_req,
   input wire logic ack_gated_mode,
   input wire logic point_has_code,
   input wire logic [ACH_CODE_W-1:0] point_code,
   input wire logic segment_done,
   input wire logic last_point,
   input wire logic [ACH_CNT_W-1:0] decel_cycles,
   // External stop pin
   input wire logic ext_stop_pin,
   // Health of axis and encoder
   input wire ach_err_type axis_err,
   input wire ach_err_type encoder_err,
   // Power-up position check
   input wire logic powerup_check,
   input wire logic [ACH_POS_W-1:0] encoder_pos,
   input wire logic [ACH_POS_W-1:0] saved_pos,
   // Status
   output ach_stat_type status,
   output logic [ACH_CODE_W-1:0] mcode_out,
   output logic [ACH_CODE_W-1:0] axis_minor_fault_code,
   output logic [ACH_CODE_W-1:0] axis_major_fault_code,
   output logic [ACH_CODE_W-1:0] encoder_minor_fault_code,
   output logic [ACH_CODE_W-1:0] encoder_major_fault_code
);

   ach_state_type st_q, st_d;
   ach_stat_type s_q, s_d;
   ach_cmd_type rise, fall;
   logic [ACH_CMD_W-1:0] rise_v, fall_v;
   logic [ACH_CNT_W-1:0] cnt_q, cnt_d;
   logic [ACH_CODE_W-1:0] mcode_q, mcode_d;
   logic [ACH_CODE_W-1:0] amin_q, amin_d, amaj_q, amaj_d;
   logic [ACH_CODE_W-1:0] emin_q, emin_d, emaj_q, emaj_d;
   logic gated_q, gated_d, ack_up_q, ack_up_d, released_q, released_d;
   logic pin_meta_q, pin_sync_q, pin_prev_q;
   logic pin_rise, ax_bad, enc_bad, halt_any, may_start;

   // Command edges per scan
   ach_scan_edge #(.WIDTH(ACH_CMD_W)) u_edge (
      .ref_clk(ref_clk),
      .srst(srst),
      .scan_tick(scan_tick),
      .bits_in(cmd),
      .rise(rise_v),
      .fall(fall_v)
   );
   assign rise = rise_v;
   assign fall = fall_v;

   // Stop pin synchroniser and edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_meta_q <= ext_stop_pin;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end
   assign pin_rise = pin_sync_q & ~pin_prev_q;

   // Health and stop qualifiers
   assign ax_bad = axis_err.minor | axis_err.major;
   assign enc_bad = encoder_err.minor | encoder_err.major;
   assign halt_any = rise.stop_cmd | rise.rapid_stop_cmd | pin_rise;
   assign may_start = ~cmd.stop_cmd & ~cmd.rapid_stop_cmd
      & (cmd.ext_halt_ignore_cmd | ~pin_sync_q);

   // Motion, handshake and status next values
   always_comb begin
      st_d = st_q;
      s_d = s_q;
      cnt_d = cnt_q;
      mcode_d = mcode_q;
      gated_d = gated_q;
      ack_up_d = ack_up_q;
      released_d = released_q;
      s_d.advance = 1'b0;
      s_d.start_refused = 1'b0;
      // Ack handshake: rise clears pending, later fall releases
      if (s_q.code_pending_flag && rise.handshake_ack) begin
         s_d.code_pending_flag = 1'b0;
         ack_up_d = 1'b1;
      end
      if (ack_up_q && !s_q.code_pending_flag && fall.handshake_ack) begin
         released_d = 1'b1;
      end
      if (rise.cancel_cmd || rise.skip_cmd) begin
         s_d.code_pending_flag = 1'b0;
      end
      if (rise.completion_clear_cmd) begin
         s_d.start_done_flag = 1'b0;
         s_d.position_done_flag = 1'b0;
      end
      case (st_q)
         ACH_IDLE: begin
            if (scan_tick && cmd.forward_inch_cmd) begin
               st_d = ACH_INCH_FWD;
            end else if (scan_tick && cmd.reverse_inch_cmd) begin
               st_d = ACH_INCH_REV;
            end else if (start_req && !may_start) begin
               s_d.start_refused = 1'b1;
            end else if (start_req) begin
               st_d = ACH_MOVE;
               s_d.start_done_flag = 1'b1;
               s_d.position_done_flag = 1'b0;
               gated_d = ack_gated_mode & point_has_code;
               ack_up_d = 1'b0;
               released_d = 1'b0;
               if (point_has_code) begin
                  mcode_d = point_code;
               end
               s_d.code_pending_flag = gated_d;
            end
         end
         ACH_INCH_FWD: begin
            if (halt_any || (scan_tick && !cmd.forward_inch_cmd)) begin
               st_d = ACH_DECEL;
               cnt_d = decel_cycles;
            end
         end
         ACH_INCH_REV: begin
            if (halt_any || (scan_tick && !cmd.reverse_inch_cmd)) begin
               st_d = ACH_DECEL;
               cnt_d = decel_cycles;
            end
         end
         ACH_MOVE, ACH_ACK_WAIT: begin
            if (halt_any) begin
               st_d = ACH_DECEL;
               cnt_d = decel_cycles;
               s_d.code_pending_flag = 1'b0;
            end else if ((st_q == ACH_MOVE && segment_done && !(gated_q && !released_q))
                  || (st_q == ACH_ACK_WAIT && released_q)) begin
               s_d.advance = 1'b1;
               gated_d = 1'b0;
               if (last_point) begin
                  st_d = ACH_IDLE;
                  s_d.position_done_flag = 1'b1;
                  s_d.start_done_flag = 1'b0;
               end else begin
                  st_d = ACH_MOVE;
                  gated_d = ack_gated_mode & point_has_code;
                  ack_up_d = 1'b0;
                  released_d = 1'b0;
                  if (point_has_code) begin
                     mcode_d = point_code;
                  end
                  s_d.code_pending_flag = gated_d;
               end
            end else if (st_q == ACH_MOVE && segment_done) begin
               st_d = ACH_ACK_WAIT;
            end
         end
         ACH_DECEL: begin
            // Further stops are ignored while slowing down
            if (cnt_q == ACH_CNT_RST) begin
               st_d = ACH_IDLE;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         default: begin
            st_d = ACH_IDLE;
         end
      endcase
      s_d.move_fwd = (st_d == ACH_INCH_FWD);
      s_d.move_rev = (st_d == ACH_INCH_REV);
      s_d.decel = (st_d == ACH_DECEL);
      // Set wins over clear for both fault flags
      s_d.axis_fault_flag = ax_bad
         | (s_q.axis_fault_flag & ~rise.axis_error_clear_cmd);
      s_d.encoder_fault_flag = enc_bad
         | (s_q.encoder_fault_flag & ~rise.encoder_error_clear_cmd);
      // Position compared against the saved one only on the power-up pulse
      if (powerup_check) begin
         s_d.resume_blocked_warning = (encoder_pos != saved_pos);
      end
   end

   // Fault code words, latched while faulty and reset by a clear once healthy
   always_comb begin
      amin_d = amin_q;
      amaj_d = amaj_q;
      emin_d = emin_q;
      emaj_d = emaj_q;
      if (ax_bad) begin
         amin_d = axis_err.minor_code;
         amaj_d = axis_err.major_code;
      end else if (rise.axis_error_clear_cmd) begin
         amin_d = ACH_CODE_RST;
         amaj_d = ACH_CODE_RST;
      end
      if (enc_bad) begin
         emin_d = encoder_err.minor_code;
         emaj_d = encoder_err.major_code;
      end else if (rise.encoder_error_clear_cmd) begin
         emin_d = ACH_CODE_RST;
         emaj_d = ACH_CODE_RST;
      end
   end

   // Registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= ACH_IDLE;
         s_q <= ACH_STAT_RST;
         cnt_q <= ACH_CNT_RST;
         mcode_q <= ACH_CODE_RST;
         amin_q <= ACH_CODE_RST;
         amaj_q <= ACH_CODE_RST;
         emin_q <= ACH_CODE_RST;
         emaj_q <= ACH_CODE_RST;
         gated_q <= 1'b0;
         ack_up_q <= 1'b0;
         released_q <= 1'b0;
      end else begin
         st_q <= st_d;
         s_q <= s_d;
         cnt_q <= cnt_d;
         mcode_q <= mcode_d;
         amin_q <= amin_d;
         amaj_q <= amaj_d;
         emin_q <= emin_d;
         emaj_q <= emaj_d;
         gated_q <= gated_d;
         ack_up_q <= ack_up_d;
         released_q <= released_d;
      end
   end

   // Outputs
   assign status = s_q;
   assign mcode_out = mcode_q;
   assign axis_minor_fault_code = amin_q;
   assign axis_major_fault_code = amaj_q;
   assign encoder_minor_fault_code = emin_q;
   assign encoder_major_fault_code = emaj_q;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_inch_fwd_req;
      st_q == ACH_IDLE && scan_tick && cmd.forward_inch_cmd;
   endsequence
   sequence s_waiting;
      st_q == ACH_ACK_WAIT && !released_q && !halt_any;
   endsequence
   sequence s_coded_start;
      st_q == ACH_IDLE && start_req && may_start && point_has_code
         && !(scan_tick && (cmd.forward_inch_cmd || cmd.reverse_inch_cmd));
   endsequence

   a_inch_fwd_run: assert property (s_inch_fwd_req |=> status.move_fwd && !status.move_rev)
      else $error("forward inching not started");
   a_inch_stop_decel: assert property (
      st_q == ACH_INCH_REV && scan_tick && !cmd.reverse_inch_cmd
      |=> status.decel && st_q == ACH_DECEL && cnt_q == $past(decel_cycles))
      else $error("inching release without deceleration");
   a_clear_done: assert property (rise.completion_clear_cmd && st_q == ACH_IDLE && !start_req
      |=> !status.start_done_flag && !status.position_done_flag)
      else $error("completion clear ignored");
   a_err_clear_ok: assert property (rise.axis_error_clear_cmd && !ax_bad
      |=> !status.axis_fault_flag && axis_minor_fault_code == ACH_CODE_RST
      && axis_major_fault_code == ACH_CODE_RST)
      else $error("axis error clear failed");
   a_err_clear_keep: assert property (rise.axis_error_clear_cmd && ax_bad
      |=> status.axis_fault_flag && axis_minor_fault_code == $past(axis_err.minor_code))
      else $error("persisting axis fault lost");
   a_halt_refuse: assert property (st_q == ACH_IDLE && start_req && pin_sync_q
      && !cmd.ext_halt_ignore_cmd && !scan_tick
      |=> status.start_refused && st_q == ACH_IDLE)
      else $error("start taken with stop input valid");
   a_pend_start: assert property (s_coded_start
      |=> mcode_out == $past(point_code) && status.code_pending_flag == $past(ack_gated_mode))
      else $error("code pending wrong at start");
   a_ack_clears: assert property (status.code_pending_flag && rise.handshake_ack
      |=> !status.code_pending_flag)
      else $error("ack rise did not clear pending");
   a_no_early_step: assert property (s_waiting |=> !status.advance)
      else $error("step before ack off on off");
   a_release_step: assert property (st_q == ACH_ACK_WAIT && released_q && !halt_any
      |=> status.advance)
      else $error("released wait did not step");
   a_enc_fault: assert property (enc_bad |=> status.encoder_fault_flag
      && encoder_minor_fault_code == $past(encoder_err.minor_code)
      && encoder_major_fault_code == $past(encoder_err.major_code))
      else $error("encoder fault not recorded");
   a_enc_clear: assert property (rise.encoder_error_clear_cmd && !enc_bad
      |=> !status.encoder_fault_flag)
      else $error("encoder fault not dropped");

endmodule : ach_axis

// ==== hdl/ach_pkg.sv ====
package ach_pkg;

   // Data widths
   localparam int ACH_CODE_W = 16;
   localparam int ACH_POS_W = 32;
   localparam int ACH_CNT_W = 16;
   localparam int ACH_CMD_W = 11;

   // Reset values
   localparam logic [ACH_CODE_W-1:0] ACH_CODE_RST = 16'h0000;
   localparam logic [ACH_CNT_W-1:0] ACH_CNT_RST = 16'h0000;

   // Axis motion states
   typedef enum logic [2:0] {
      ACH_IDLE = 3'h0,
      ACH_INCH_FWD = 3'h1,
      ACH_INCH_REV = 3'h2,
      ACH_MOVE = 3'h3,
      ACH_ACK_WAIT = 3'h4,
      ACH_DECEL = 3'h5
   } ach_state_type;

   // Command bits from the sequence program, MSB first
   typedef struct packed {
      logic forward_inch_cmd;
      logic reverse_inch_cmd;
      logic completion_clear_cmd;
      logic axis_error_clear_cmd;
      logic ext_halt_ignore_cmd;
      logic handshake_ack;
      logic encoder_error_clear_cmd;
      logic stop_cmd;
      logic rapid_stop_cmd;
      logic cancel_cmd;
      logic skip_cmd;
   } ach_cmd_type;

   // Error report from a monitored unit
   typedef struct packed {
      logic minor;
      logic major;
      logic [ACH_CODE_W-1:0] minor_code;
      logic [ACH_CODE_W-1:0] major_code;
   } ach_err_type;

   // Status and motion request bits
   typedef struct packed {
      logic move_fwd;
      logic move_rev;
      logic decel;
      logic advance;
      logic start_refused;
      logic start_done_flag;
      logic position_done_flag;
      logic code_pending_flag;
      logic axis_fault_flag;
      logic encoder_fault_flag;
      logic resume_blocked_warning;
   } ach_stat_type;

   localparam ach_stat_type ACH_STAT_RST = '0;

endpackage : ach_pkg

// ==== hdl/ach_scan_edge.sv ====
module ach_scan_edge import ach_pkg::*; #(
   parameter int WIDTH = ACH_CMD_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Scan sampling
   input wire logic scan_tick,
   input wire logic [WIDTH-1:0] bits_in,
   // Edges seen at this scan
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   // Refuse a width the edge logic cannot serve
   if (WIDTH < 1) begin : g_width_check
      $error("ach_scan_edge: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] prev_q;
   logic [WIDTH-1:0] prev_d;

   // Previous scan value only moves on a scan
   always_comb begin
      prev_d = scan_tick ? bits_in : prev_q;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prev_q <= '0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Edges against the previous scan
   assign rise = {WIDTH{scan_tick}} & bits_in & ~prev_q;
   assign fall = {WIDTH{scan_tick}} & ~bits_in & prev_q;

endmodule : ach_scan_edge

// ==== tb/ach_prog_model.sv ====
module ach_prog_model import ach_pkg::*; #(
   parameter int SCAN = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Scan pacing and command bits
   output logic scan_tick,
   output ach_cmd_type cmd,
   // External stop input
   output logic ext_stop_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt = 0;

   // One scan tick every SCAN cycles, changed on the falling edge
   always @(negedge ref_clk) begin
      cnt <= srst ? 0 : (cnt + 1) % SCAN;
   end
   assign scan_tick = (cnt == 0);

   // Idle command word and released stop input
   initial begin
      cmd = '0;
      ext_stop_pin = 1'b0;
   end

   // Present a command word just before a tick, then hold it for n scans, or for 2 when n is less and completion clear newly rises
   task automatic put(input ach_cmd_type c, input int n);
      int k;
      k = n;
      if (c.forward_inch_cmd && c.reverse_inch_cmd) c.reverse_inch_cmd = 1'b0;
      if (c.completion_clear_cmd && !cmd.completion_clear_cmd && k < 2) k = 2;
      repeat (SCAN) begin
         #1;
         if (cnt == SCAN - 1) break;
         @(negedge ref_clk);
      end
      @(negedge ref_clk);
      cmd <= c;
      repeat (k * SCAN) @(negedge ref_clk);
   endtask : put

   // Drive the stop input to a level
   task automatic pin(input logic v);
      ext_stop_pin <= v;
   endtask : pin

   // Off then on, so a halt after an ignored start sees a fresh edge
   task automatic halt_pin();
      pin(1'b0);
      repeat (SCAN) @(negedge ref_clk);
      pin(1'b1);
   endtask : halt_pin

endmodule : ach_prog_model

// ==== tb/ach_axis_tb.sv ====
module ach_axis_tb import ach_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic scan_tick;
   logic ext_stop_pin;
   ach_cmd_type cmd;
   logic start_req = 1'b0;
   logic ack_gated_mode = 1'b0;
   logic point_has_code = 1'b0;
   logic [ACH_CODE_W-1:0] point_code = '0;
   logic segment_done = 1'b0;
   logic last_point = 1'b0;
   logic [ACH_CNT_W-1:0] decel_len = 16'h0003;
   logic powerup_check = 1'b0;
   logic [ACH_POS_W-1:0] encoder_pos = '0;
   logic [ACH_POS_W-1:0] saved_pos = '0;
   ach_err_type axis_err = '0;
   ach_err_type encoder_err = '0;
   ach_stat_type status;
   logic [ACH_CODE_W-1:0] mcode_out;
   logic [ACH_CODE_W-1:0] ax_mn;
   logic [ACH_CODE_W-1:0] ax_mj;
   logic [ACH_CODE_W-1:0] en_mn;
   logic [ACH_CODE_W-1:0] en_mj;
   ach_cmd_type cv = '0;
   int err_total = 0;
   int checked = 0;
   int adv_n = 0;
   int ref_n = 0;
   int a0;

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // Count the one-cycle status pulses
   always @(posedge ref_clk) begin
      if (status.advance === 1'b1) adv_n++;
      if (status.start_refused === 1'b1) ref_n++;
   end

   ach_prog_model #(.SCAN(4)) u_prog (
      .ref_clk(ref_clk),
      .srst(srst),
      .scan_tick(scan_tick),
      .cmd(cmd),
      .ext_stop_pin(ext_stop_pin)
   );

   ach_axis u_dut (
      .ref_clk(ref_clk),
      .srst(srst),
      .scan_tick(scan_tick),
      .cmd(cmd),
      .start_req(start_req),
      .ack_gated_mode(ack_gated_mode),
      .point_has_code(point_has_code),
      .point_code(point_code),
      .segment_done(segment_done),
      .last_point(last_point),
      .decel_cycles(decel_len),
      .ext_stop_pin(ext_stop_pin),
      .axis_err(axis_err),
      .encoder_err(encoder_err),
      .powerup_check(powerup_check),
      .encoder_pos(encoder_pos),
      .saved_pos(saved_pos),
      .status(status),
      .mcode_out(mcode_out),
      .axis_minor_fault_code(ax_mn),
      .axis_major_fault_code(ax_mj),
      .encoder_minor_fault_code(en_mn),
      .encoder_major_fault_code(en_mj)
   );

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      if (err_total == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // Request a positioning start from idle
   task automatic start(input logic g, input logic hc, input logic [ACH_CODE_W-1:0] code);
      ack_gated_mode = g;
      point_has_code = hc;
      point_code = code;
      start_req = 1'b1;
      cyc(1);
      start_req = 1'b0;
      cyc(2);
   endtask : start

   // Trajectory reports the current point finished
   task automatic seg();
      segment_done = 1'b1;
      cyc(1);
      segment_done = 1'b0;
      cyc(2);
   endtask : seg

   // Completion clear held over two scans
   task automatic clr();
      cv.completion_clear_cmd = 1'b1;
      u_prog.put(cv, 1);
      chk(status.start_done_flag, 0);
      chk(status.position_done_flag, 0);
      cv.completion_clear_cmd = 1'b0;
      u_prog.put(cv, 1);
   endtask : clr

   // Fault raised, cleared while present, then cleared once healthy
   task automatic fault(input bit enc);
      if (enc) encoder_err = {1'b1, 1'b1, 16'h0123, 16'h0456};
      else axis_err = {1'b1, 1'b0, 16'h0123, 16'h0456};
      cyc(2);
      chk(enc ? status.encoder_fault_flag : status.axis_fault_flag, 1);
      chk(enc ? en_mn : ax_mn, 16'h0123);
      chk(enc ? en_mj : ax_mj, 16'h0456);
      for (int p = 0; p < 2; p++) begin
         if (enc) cv.encoder_error_clear_cmd = 1'b1;
         else cv.axis_error_clear_cmd = 1'b1;
         u_prog.put(cv, 1);
         chk(enc ? status.encoder_fault_flag : status.axis_fault_flag, p == 0);
         chk(enc ? en_mn : ax_mn, (p == 0) ? 16'h0123 : 16'h0000);
         chk(enc ? en_mj : ax_mj, (p == 0) ? 16'h0456 : 16'h0000);
         cv = '0;
         u_prog.put(cv, 1);
         axis_err = '0;
         encoder_err = '0;
         cyc(2);
      end
   endtask : fault

   // Cut a hung run short
   initial begin
      #(100000 * 10);
      err_total++;
      summarize();
   end

   // Main sequence
   initial begin
      cyc(16);
      srst = 1'b0;
      cyc(2);
      for (int d = 0; d < 2; d++) begin
         cv.forward_inch_cmd = (d == 0);
         cv.reverse_inch_cmd = (d == 1);
         u_prog.put(cv, 1);
         chk(d ? status.move_rev : status.move_fwd, 1);
         cv = '0;
         u_prog.put(cv, 1);
         chk(status.decel, 1);
         chk(status.move_fwd | status.move_rev, 0);
         cyc(4);
         chk(status.decel, 0);
      end
      // Acknowledge-gated coded point, last of the program
      last_point = 1'b1;
      start(1'b1, 1'b1, 16'h0a5a);
      chk(status.start_done_flag, 1);
      chk(status.code_pending_flag, 1);
      chk(mcode_out, 16'h0a5a);
      a0 = adv_n;
      seg();
      cyc(4);
      chk(adv_n, a0);
      cv.handshake_ack = 1'b1;
      u_prog.put(cv, 1);
      chk(status.code_pending_flag, 0);
      chk(adv_n, a0);
      cv.handshake_ack = 1'b0;
      u_prog.put(cv, 1);
      cyc(2);
      chk(adv_n, a0 + 1);
      chk(status.position_done_flag, 1);
      chk(status.start_done_flag, 0);
      clr();
      // Coded point without gating, then rapid stop
      last_point = 1'b0;
      start(1'b0, 1'b1, 16'h00c3);
      chk(status.code_pending_flag, 0);
      chk(mcode_out, 16'h00c3);
      a0 = adv_n;
      seg();
      chk(adv_n, a0 + 1);
      cv.rapid_stop_cmd = 1'b1;
      u_prog.put(cv, 1);
      chk(status.decel, 1);
      cv = '0;
      u_prog.put(cv, 1);
      clr();
      // External stop level blocks a start unless ignored
      u_prog.pin(1'b1);
      cyc(6);
      a0 = ref_n;
      start(1'b0, 1'b0, 16'h0000);
      chk(ref_n, a0 + 1);
      chk(status.start_done_flag, 0);
      cv.ext_halt_ignore_cmd = 1'b1;
      u_prog.put(cv, 1);
      start(1'b0, 1'b0, 16'h0000);
      chk(status.start_done_flag, 1);
      u_prog.halt_pin();
      cyc(5);
      chk(status.decel, 1);
      u_prog.pin(1'b0);
      cv = '0;
      u_prog.put(cv, 2);
      // Stop, cancel and skip each drop the pending code
      for (int i = 0; i < 3; i++) begin
         start(1'b1, 1'b1, 16'h0011);
         cv.stop_cmd = (i == 0);
         cv.cancel_cmd = (i == 1);
         cv.skip_cmd = (i == 2);
         u_prog.put(cv, 1);
         chk(status.code_pending_flag, 0);
         cv = '0;
         cv.stop_cmd = 1'b1;
         u_prog.put(cv, 1);
         cv = '0;
         u_prog.put(cv, 1);
      end
      fault(1'b0);
      fault(1'b1);
      // Saved position compared at power-up
      saved_pos = 32'h0000_1234;
      for (int m = 0; m < 2; m++) begin
         encoder_pos = saved_pos + m;
         powerup_check = 1'b1;
         cyc(1);
         powerup_check = 1'b0;
         cyc(2);
         chk(status.resume_blocked_warning, m == 1);
      end
      summarize();
   end

endmodule : ach_axis_tb
